// ### inc/vic_params.svh
// Register offsets, field positions, reset values and sizes for the vectored interrupt unit.
`ifndef VIC_PARAMS_SVH
`define VIC_PARAMS_SVH
`define VIC_OFF_CTRL 8'h00
`define VIC_OFF_CHAN 8'h04
`define VIC_OFF_PRIO 8'h08
`define VIC_OFF_VECT 8'h18
`define VIC_OFF_FAST 8'h1C
`define VIC_OFF_ENAB 8'h20
`define VIC_OFF_PEND 8'h40
`define VIC_OFF_SRC0 8'h60
`define VIC_OFF_SRCN 8'hDC
`define VIC_NCHAN 32
`define VIC_STACK_DEPTH 16
`define VIC_CTRL_NORM_BIT 0
`define VIC_CTRL_FAST_BIT 1
`define VIC_ZERO32 32'h00000000
`endif

// ### inc/vic_pkg.sv
// Types shared by the vectored interrupt unit.
package vic_pkg;
   typedef logic [3:0] vic_prio_t;
   typedef logic [4:0] vic_chan_t;
   typedef struct packed
   {
      vic_prio_t prio;
      vic_chan_t chan;
   } vic_frame_s;
   typedef enum logic [1:0]
   {
      VIC_IDLE = 2'b00,
      VIC_WAIT = 2'b01
   } vic_state_e;
endpackage

// ### design/vic_unit.sv
// Vectored, priority nested interrupt controller with a classic Wishbone slave.
// Function
// - Current priority is a 4-bit field, reset to zero, other bits read zero.
// - Current priority loads on an acknowledging vector read, on a stack pop, and on an accepted priority write.
// - Normal request asserts when enabled and a pending channel outranks current priority.
// - Priority writes at or above serviced channel priority accepted while a channel is in service (stack not empty), all others ignored.
// - Vector read releases request, updates priority and channel, masks lower levels.
// - Vector low half is the winning channel vector field, read only.
// - Vector high half is one shared read-write value set by software.
// - Vector read acknowledges only outside debug and in normal interrupt mode.
// - Each fast channel latches requests only while its enable bit is set; a latched pending bit still drives the fast output.
// - Fast pending bits set by hardware, cleared by writing one.
// - Enable register, one bit per channel, gates pending bit setting.
// - Pending bit per channel set on enabled request, cleared by writing one.
// - Clearing serviced channel pending bit is end of service and pops stack.
// - Request line stays asserted if pending cleared before vector read.
// - Early clear of serviced pending bit still pops the stack.
// - While normal output enable is clear the stack is frozen, no pop.
// - Control bit 0 gates normal output, bit 1 gates fast output.
// - Fast output asserts when enabled and any fast pending bit is set.
// - Each channel has priority and vector fields; priority zero never requests.
// - Current channel number updates one cycle after the acknowledging read.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`include "vic_params.svh"
module vic_unit
   import vic_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [31:0] chan_req_i,
   input wire logic [1:0] fast_req_i,
   input wire logic cpu_debug_i,
   input wire logic cpu_irq_mode_i,
   output logic normal_request_n_o,
   output logic fast_request_n_o
);

////////////////////////////////////////////////////////////////////////////////
// Register state.
logic [1:0] output_control_r;
logic [3:0] current_priority_field_r;
vic_chan_t current_channel_number_r;
logic [15:0] vector_base_r;
logic [1:0] fast_enable_bits_r;
logic [1:0] fast_pending_bits_r;
logic [31:0] channel_enable_bits_r;
logic [31:0] channel_pending_bits_r;
logic [3:0] channel_priority_field_r [0:`VIC_NCHAN-1];
logic [15:0] channel_vector_field_r [0:`VIC_NCHAN-1];
vic_frame_s stack_r [0:`VIC_STACK_DEPTH-1];
logic [4:0] stack_ptr_r;
vic_state_e state_r;
logic [3:0] serviced_prio_r;
// A push onto a full stack lands on the top entry, so the deepest frames survive.
logic [3:0] push_idx;
assign push_idx = (stack_ptr_r == 5'(`VIC_STACK_DEPTH)) ? 4'(`VIC_STACK_DEPTH - 1)
   : stack_ptr_r[3:0];
logic ack_pend_r;
vic_chan_t ack_chan_r;

////////////////////////////////////////////////////////////////////////////////
// Bus decode. Each access is answered one cycle after it is presented.
logic bus_req;
logic wr_stb;
logic rd_stb;
logic full_word;
assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign wr_stb = bus_req & wb_we_i;
assign rd_stb = bus_req & ~wb_we_i;
assign full_word = (wb_sel_i == 4'hF);

logic src_hit;
vic_chan_t src_idx;
assign src_hit = (wb_adr_i >= `VIC_OFF_SRC0) && (wb_adr_i <= `VIC_OFF_SRCN)
   && (wb_adr_i[1:0] == 2'b00);
assign src_idx = vic_chan_t'((wb_adr_i - `VIC_OFF_SRC0) >> 2);

////////////////////////////////////////////////////////////////////////////////
// Priority decoder: highest level among enabled pending channels, lowest index on a tie.
logic [3:0] win_prio;
vic_chan_t win_chan;
always_comb
begin
   win_prio = 4'h0;
   win_chan = 5'h00;
   for (int i = `VIC_NCHAN - 1; i >= 0; i--)
   begin
      if (channel_pending_bits_r[i] && channel_enable_bits_r[i]
         && channel_priority_field_r[i] >= win_prio && channel_priority_field_r[i] != 4'h0)
      begin
         win_prio = channel_priority_field_r[i];
         win_chan = vic_chan_t'(i);
      end
   end
end

logic win_valid;
assign win_valid = (win_prio > current_priority_field_r);

////////////////////////////////////////////////////////////////////////////////
// Acknowledge and end of service detection.
logic vec_ack;
assign vec_ack = rd_stb && full_word && (wb_adr_i == `VIC_OFF_VECT)
   && !cpu_debug_i && cpu_irq_mode_i && (state_r == VIC_WAIT);

logic pend_wr;
logic eos;
assign pend_wr = wr_stb && full_word && (wb_adr_i == `VIC_OFF_PEND);
// Frozen stack means a clear of the serviced bit does not pop; writing the bit again once the normal output is re-enabled does.
assign eos = pend_wr && (stack_ptr_r != 5'h00) && output_control_r[`VIC_CTRL_NORM_BIT]
   && wb_dat_i[current_channel_number_r] && !vec_ack;

////////////////////////////////////////////////////////////////////////////////
// Request state machine. Once asserted the line holds until acknowledged or until the normal output is disabled.
always_ff @(posedge clk_i)
begin
   if (rst_i)
      state_r <= VIC_IDLE;
   else
   begin
      case (state_r)
         VIC_IDLE:
            if (win_valid && output_control_r[`VIC_CTRL_NORM_BIT])
               state_r <= VIC_WAIT;
         VIC_WAIT:
            if (vec_ack)
               state_r <= VIC_IDLE;
            else if (!output_control_r[`VIC_CTRL_NORM_BIT])
               state_r <= VIC_IDLE;
         default:
            state_r <= VIC_IDLE;
      endcase
   end
end

// Outputs come from flops; active low request lines.
always_ff @(posedge clk_i)
begin
   if (rst_i)
   begin
      normal_request_n_o <= 1'b1;
      fast_request_n_o <= 1'b1;
   end
   else
   begin
      normal_request_n_o <= !((state_r == VIC_WAIT) && !vec_ack
         && output_control_r[`VIC_CTRL_NORM_BIT]);
      fast_request_n_o <= !(output_control_r[`VIC_CTRL_FAST_BIT]
         && (fast_pending_bits_r != 2'b00));
   end
end

////////////////////////////////////////////////////////////////////////////////
// Priority stack, current priority and serviced channel.
always_ff @(posedge clk_i)
begin
   if (rst_i)
   begin
      current_priority_field_r <= 4'h0;
      serviced_prio_r <= 4'h0;
      stack_ptr_r <= 5'h00;
      ack_pend_r <= 1'b0;
      ack_chan_r <= 5'h00;
   end
   else
   begin
      ack_pend_r <= vec_ack;
      if (vec_ack)
      begin
         stack_r[push_idx] <= '{prio: current_priority_field_r,
            chan: current_channel_number_r};
         if (stack_ptr_r != 5'(`VIC_STACK_DEPTH))
            stack_ptr_r <= stack_ptr_r + 5'h01;
         current_priority_field_r <= win_prio;
         serviced_prio_r <= win_prio;
         ack_chan_r <= win_chan;
      end
      else if (eos)
      begin
         stack_ptr_r <= stack_ptr_r - 5'h01;
         current_priority_field_r <= stack_r[stack_ptr_r[3:0] - 4'h1].prio;
         serviced_prio_r <= stack_r[stack_ptr_r[3:0] - 4'h1].prio;
      end
      else if (wr_stb && full_word && (wb_adr_i == `VIC_OFF_PRIO)
         && (stack_ptr_r != 5'h00) && (wb_dat_i[3:0] >= serviced_prio_r))
         current_priority_field_r <= wb_dat_i[3:0];
   end
end

// The channel number follows the acknowledge by one cycle; a pop restores it directly.
always_ff @(posedge clk_i)
begin
   if (rst_i)
      current_channel_number_r <= 5'h00;
   else if (ack_pend_r)
      current_channel_number_r <= ack_chan_r;
   else if (eos)
      current_channel_number_r <= stack_r[stack_ptr_r[3:0] - 4'h1].chan;
end

////////////////////////////////////////////////////////////////////////////////
// Control, vector base, enables.
always_ff @(posedge clk_i)
begin
   if (rst_i)
   begin
      output_control_r <= 2'b00;
      vector_base_r <= 16'h0000;
      fast_enable_bits_r <= 2'b00;
      channel_enable_bits_r <= `VIC_ZERO32;
   end
   else if (wr_stb && full_word)
   begin
      case (wb_adr_i)
         `VIC_OFF_CTRL: output_control_r <= wb_dat_i[1:0];
         `VIC_OFF_VECT: vector_base_r <= wb_dat_i[31:16];
         `VIC_OFF_FAST: fast_enable_bits_r <= wb_dat_i[1:0];
         `VIC_OFF_ENAB: channel_enable_bits_r <= wb_dat_i;
         default: ;
      endcase
   end
end

// Per-channel source config; reset clears both the priority and the vector fields to zero.
genvar g;
generate
   for (g = 0; g < `VIC_NCHAN; g++)
   begin : g_src
      always_ff @(posedge clk_i)
      begin
         if (rst_i)
         begin
            channel_priority_field_r[g] <= 4'h0;
            channel_vector_field_r[g] <= 16'h0000;
         end
         else if (wr_stb && full_word && src_hit && (src_idx == vic_chan_t'(g)))
         begin
            channel_priority_field_r[g] <= wb_dat_i[3:0];
            channel_vector_field_r[g] <= wb_dat_i[31:16];
         end
      end
   end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Pending flags: a request in the same cycle as its clear keeps the bit set.
always_ff @(posedge clk_i)
begin
   if (rst_i)
   begin
      channel_pending_bits_r <= `VIC_ZERO32;
      fast_pending_bits_r <= 2'b00;
   end
   else
   begin
      channel_pending_bits_r <= (channel_pending_bits_r & ~(pend_wr ? wb_dat_i : `VIC_ZERO32))
         | (chan_req_i & channel_enable_bits_r);
      fast_pending_bits_r <= (fast_pending_bits_r
         & ~((wr_stb && full_word && wb_adr_i == `VIC_OFF_FAST) ? wb_dat_i[3:2] : 2'b00))
         | (fast_req_i & fast_enable_bits_r);
   end
end

////////////////////////////////////////////////////////////////////////////////
// Read data mux and acknowledge.
logic [31:0] rd_data;
always_comb
begin
   rd_data = `VIC_ZERO32;
   case (wb_adr_i)
      `VIC_OFF_CTRL: rd_data = {30'h0, output_control_r};
      `VIC_OFF_CHAN: rd_data = {27'h0, current_channel_number_r};
      `VIC_OFF_PRIO: rd_data = {28'h0, current_priority_field_r};
      `VIC_OFF_VECT: rd_data = {vector_base_r, channel_vector_field_r[win_chan]};
      `VIC_OFF_FAST: rd_data = {28'h0, fast_pending_bits_r, fast_enable_bits_r};
      `VIC_OFF_ENAB: rd_data = channel_enable_bits_r;
      `VIC_OFF_PEND: rd_data = channel_pending_bits_r;
      default:
         if (src_hit)
            rd_data = {channel_vector_field_r[src_idx], 12'h000,
               channel_priority_field_r[src_idx]};
   endcase
end

always_ff @(posedge clk_i)
begin
   if (rst_i)
   begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `VIC_ZERO32;
   end
   else
   begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rd_stb ? rd_data : `VIC_ZERO32;
   end
end

endmodule // vic_unit

// ### sim/vic_unit_asserts.sv
// Port-level checks for the vectored interrupt unit.
`timescale 1ns/1ps
module vic_unit_asserts
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [31:0] chan_req_i,
   input wire logic [1:0] fast_req_i,
   input wire logic cpu_debug_i,
   input wire logic cpu_irq_mode_i,
   input wire logic normal_request_n_o,
   input wire logic fast_request_n_o
);
   logic [1:0] ctrl_r;
   logic [1:0] fen_r;
   logic vrd;
   logic rd;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Vector read taken this edge, and a read answered this edge.
   assign vrd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == 8'h18;
   assign rd = wb_ack_o && !wb_we_i;
   // Shadow of the enables, updated at the ack edge, one edge after the unit.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_r <= 2'h0;
         fen_r <= 2'h0;
      end
      else if (wb_ack_o && wb_cyc_i && wb_we_i && wb_sel_i == 4'hF)
      begin
         if (wb_adr_i == 8'h00)
            ctrl_r <= wb_dat_i[1:0];
         if (wb_adr_i == 8'h1C)
            fen_r <= wb_dat_i[1:0];
      end
   end
   AST_PRIO_RSV: assert property (rd && wb_adr_i == 8'h08 |-> wb_dat_o[31:4] == 28'h0)
      else $error("priority register upper bits not zero");
   AST_CHAN_RSV: assert property (rd && wb_adr_i == 8'h04 |-> wb_dat_o[31:5] == 27'h0)
      else $error("channel register upper bits not zero");
   AST_FAST_RSV: assert property (rd && wb_adr_i == 8'h1C |-> wb_dat_o[31:4] == 28'h0)
      else $error("fast register upper bits not zero");
   AST_ACK_RELEASE: assert property (vrd && wb_sel_i == 4'hF && !cpu_debug_i && cpu_irq_mode_i
      && !normal_request_n_o |-> ##[1:3] normal_request_n_o)
      else $error("vector read did not release the normal request");
   AST_NO_ACK: assert property (vrd && (cpu_debug_i || !cpu_irq_mode_i) && ctrl_r[0]
      && !normal_request_n_o |=> !normal_request_n_o [*3])
      else $error("vector read acknowledged outside normal interrupt mode");
   AST_NORM_CAUSE: assert property ($fell(normal_request_n_o) |-> $past(ctrl_r[0]))
      else $error("normal request raised while its output was disabled");
   AST_NORM_GATE: assert property (!ctrl_r[0] && !$past(ctrl_r[0]) |-> normal_request_n_o)
      else $error("normal request active with output disabled");
   AST_FAST_GATE: assert property (!ctrl_r[1] && !$past(ctrl_r[1]) |-> fast_request_n_o)
      else $error("fast request active with output disabled");
   AST_FAST_LAT: assert property (fast_req_i[0] && fen_r[0] && ctrl_r[1]
      |=> ##1 !fast_request_n_o)
      else $error("enabled fast request not raised in two cycles");
endmodule // vic_unit_asserts

// ### sim/vic_src_model.sv
// Peripheral request sources that pulse their lines on command.
`timescale 1ns/1ps
module vic_src_model
(
   input wire logic clk_i,
   input wire logic fire_i,
   input wire logic [31:0] mask_i,
   input wire logic [1:0] fmask_i,
   output logic [31:0] chan_req_o = 32'h00000000,
   output logic [1:0] fast_req_o = 2'h0
);
   // One-cycle pulses: the unit must latch them, a held level would hide that.
   always @(posedge clk_i)
   begin
      chan_req_o <= fire_i ? mask_i : 32'h00000000;
      fast_req_o <= fire_i ? fmask_i : 2'h0;
   end
endmodule // vic_src_model

// ### sim/vic_unit_tb.sv
// Self-checking bench for the vectored interrupt unit.
`timescale 1ns/1ps
module vic_unit_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic fire = 1'b0;
   logic dbg = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] mask = 32'h00000000;
   logic [1:0] fmask = 2'h0;
   logic [31:0] rdat;
   logic [31:0] chan_req;
   logic [1:0] fast_req;
   logic [31:0] dat_o;
   logic ack;
   logic nreq_n;
   logic freq_n;
   logic [7:0] offs [8] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h1C, 8'h20, 8'h40, 8'h10};
   int error_cnt = 0;
   int compares = 0;
   // 40 MHz clock.
   always #12.5 clk_i = ~clk_i;
   vic_unit vic_unit_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .chan_req_i(chan_req), .fast_req_i(fast_req), .cpu_debug_i(dbg),
      .cpu_irq_mode_i(1'b1), .normal_request_n_o(nreq_n), .fast_request_n_o(freq_n));
   vic_src_model vic_src_model_inst (.clk_i(clk_i), .fire_i(fire), .mask_i(mask),
      .fmask_i(fmask), .chan_req_o(chan_req), .fast_req_o(fast_req));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Classic single cycle; waits for ack under a bound.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 30);
      rdat = dat_o;
      cyc <= 1'b0;
      if (n >= 30)
      begin
         error_cnt++;
         complete_run();
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000);
      chk($sformatf("register %h", a), rdat, e);
   endtask
   task automatic wait_req(input logic lvl);
      int n;
      n = 0;
      while (nreq_n !== lvl && n < 30)
      begin
         @(posedge clk_i);
         n++;
      end
      chk("normal request", {31'h0, nreq_n}, {31'h0, lvl});
      if (n >= 30)
         complete_run();
   endtask
   task automatic pulse(input logic [31:0] m, input logic [1:0] f);
      @(posedge clk_i);
      mask <= m;
      fmask <= f;
      fire <= 1'b1;
      @(posedge clk_i);
      fire <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   // Main sequence.
   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b1, 8'h10, 32'hFFFFFFFF);
      foreach (offs[i]) rc(offs[i], 32'h00000000);
      $display("test reset done");
      bus(1'b1, 8'h18, 32'hABCD0000);
      bus(1'b0, 8'h18, 32'h00000000);
      chk("vector high", {16'h0, rdat[31:16]}, 32'h0000ABCD);
      bus(1'b1, 8'h6C, 32'h03330005);
      bus(1'b1, 8'h7C, 32'h07770005);
      bus(1'b1, 8'h84, 32'h09990000);
      bus(1'b1, 8'h20, 32'h00000288);
      bus(1'b1, 8'h00, 32'h00000001);
      pulse(32'h00001200, 2'h0);
      chk("idle request", {31'h0, nreq_n}, 32'h00000001);
      rc(8'h40, 32'h00000200);
      bus(1'b1, 8'h40, 32'h00000200);
      rc(8'h40, 32'h00000000);
      $display("test enable done");
      pulse(32'h00000088, 2'h0);
      wait_req(1'b0);
      rc(8'h18, 32'hABCD0333);
      wait_req(1'b1);
      rc(8'h08, 32'h00000005);
      rc(8'h04, 32'h00000003);
      bus(1'b1, 8'h08, 32'h00000004);
      rc(8'h08, 32'h00000005);
      bus(1'b1, 8'h08, 32'h00000009);
      rc(8'h08, 32'h00000009);
      bus(1'b1, 8'h08, 32'h00000005);
      bus(1'b1, 8'h40, 32'h00000008);
      rc(8'h08, 32'h00000000);
      wait_req(1'b0);
      $display("test nesting done");
      dbg <= 1'b1;
      rc(8'h08, 32'h00000000);
      bus(1'b0, 8'h18, 32'h00000000);
      wait_req(1'b0);
      dbg <= 1'b0;
      rc(8'h18, 32'hABCD0777);
      wait_req(1'b1);
      bus(1'b1, 8'h00, 32'h00000000);
      bus(1'b1, 8'h40, 32'h00000080);
      rc(8'h08, 32'h00000005);
      bus(1'b1, 8'h00, 32'h00000001);
      bus(1'b1, 8'h40, 32'h00000080);
      rc(8'h08, 32'h00000000);
      $display("test debug and freeze done");
      bus(1'b1, 8'h00, 32'h00000003);
      bus(1'b1, 8'h1C, 32'h00000001);
      pulse(32'h00000000, 2'h3);
      rc(8'h1C, 32'h00000005);
      chk("fast request", {31'h0, freq_n}, 32'h00000000);
      bus(1'b1, 8'h1C, 32'h00000005);
      rc(8'h1C, 32'h00000001);
      chk("fast request", {31'h0, freq_n}, 32'h00000001);
      pulse(32'h00000008, 2'h0);
      wait_req(1'b0);
      bus(1'b1, 8'h40, 32'h00000008);
      repeat (3) @(posedge clk_i);
      wait_req(1'b0);
      bus(1'b1, 8'h00, 32'h00000002);
      wait_req(1'b1);
      $display("test fast and release done");
      complete_run();
   end
endmodule // vic_unit_tb
bind vic_unit vic_unit_asserts vic_unit_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .chan_req_i(chan_req_i), .fast_req_i(fast_req_i), .cpu_debug_i(cpu_debug_i),
   .cpu_irq_mode_i(cpu_irq_mode_i), .normal_request_n_o(normal_request_n_o),
   .fast_request_n_o(fast_request_n_o));
